/* File: rtl/irq_ctrl_regs.vh */
// Register offsets, field layouts and reset values of the interrupt block
`ifndef IRQ_CTRL_REGS_VH
`define IRQ_CTRL_REGS_VH

`define ADDR_W 12
`define ENABLE_OFS 12'h000
`define SET_PEND_OFS 12'h004
`define CLR_PEND_OFS 12'h008
`define ACTIVE_OFS 12'h00C
`define TYPE_OFS 12'h010
`define GROUPING_OFS 12'h014
`define PRIO0_OFS 12'h018
`define PRIO1_OFS 12'h01C
`define PRIO2_OFS 12'h020
`define SW_TRIG_OFS 12'h024
`define STATUS_OFS 12'h028

`define PRIO_W 3
`define PRIO_FIELD_W 4
`define PRIO_PER_WORD 8
`define SUB_W 2
`define SUB_MAX 2'h3
`define ID_W 5
`define NO_GROUP 4'h8
`define GROUPING_RST 2'h0
`define STAT_VALID_BIT 8
`define STAT_PRIO_LSB 9
`define STAT_NMI_BIT 16

`endif

/* File: rtl/vectored_irq_pending_logic.v */
// Pending, active and priority logic of the vectored interrupt controller
//
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "irq_ctrl_regs.vh"

module vectored_irq_pending_logic
#(
	parameter NUM_IRQ = 22
)
(
	input wire core_clk,
	input wire rst_n,
	// APB register port
	input wire [`ADDR_W-1:0] paddr,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// Peripheral request lines and the non-maskable line
	input wire [NUM_IRQ-1:0] irq_in,
	input wire nmi_in,
	// Request towards the core
	output reg irq_req,
	output reg [`ID_W-1:0] irq_id,
	output reg [`PRIO_W-1:0] irq_prio,
	output reg nmi_req,
	// Handler entry and return from the core
	input wire entry,
	input wire [`ID_W-1:0] entry_id,
	input wire exit_ret,
	input wire [`ID_W-1:0] exit_id
);

	// Per-source state: enable, pending, active, type
	reg [NUM_IRQ-1:0] enable_q;
	reg [NUM_IRQ-1:0] enable_d;
	reg [NUM_IRQ-1:0] pend_q;
	reg [NUM_IRQ-1:0] pend_d;
	reg [NUM_IRQ-1:0] active_q;
	reg [NUM_IRQ-1:0] active_d;
	reg [NUM_IRQ-1:0] pulse_q;
	reg [NUM_IRQ-1:0] pulse_d;
	// Last sample of every request line, for edge detection
	reg [NUM_IRQ-1:0] line_q;

	// Priority configuration
	reg [`SUB_W-1:0] grouping_q;
	reg [`SUB_W-1:0] grouping_d;
	reg [`PRIO_W-1:0] prio_q [0:NUM_IRQ-1];
	reg [`PRIO_W-1:0] prio_d [0:NUM_IRQ-1];

	// Bus decode and read staging
	reg [31:0] rdata_d;
	reg addr_ok;

	// Arbitration results and scratch
	reg best_valid;
	reg [`ID_W-1:0] best_id;
	reg [`PRIO_W-1:0] best_prio;
	reg [3:0] run_group;
	reg [3:0] g;
	reg [NUM_IRQ-1:0] edge_in;
	// Loop indices, one per process so no two processes share one
	integer i;
	integer j;
	integer k;
	integer m;
	integer n;

	// Setup cycle stages read data; access phase commits writes.
	// pready is constant, so no wait state ever appears
	wire setup = psel & ~penable;
	wire wr_en = psel & penable & pwrite;
	// Address of the first priority word
	localparam [`ADDR_W-1:0] PRIO_BASE = `PRIO0_OFS;

	// Group part of a priority: drop the subpriority bits.
	// One bit wider so the idle marker fits above seven
	function [3:0] group_of;
		input [`PRIO_W-1:0] p;
		input [`SUB_W-1:0] sub;
		begin
			group_of = {1'b0, p >> sub};
		end
	endfunction

	// Priority word that holds the field of one source
	function prio_hit;
		input [`ADDR_W-1:0] a;
		input integer idx;
		integer q;
		begin
			q = idx / `PRIO_PER_WORD;
			prio_hit = (a[11:2] == PRIO_BASE[11:2] + q[9:0]);
		end
	endfunction

	// Bit offset of a source's field inside its word
	function integer field_lsb;
		input integer idx;
		begin
			field_lsb = (idx % `PRIO_PER_WORD) * `PRIO_FIELD_W;
		end
	endfunction

	// Every access completes in the access phase; reads were staged
	// in the setup phase so prdata comes straight from a flip-flop.
	// The price is that a read shows state as of its setup cycle,
	// one edge older than the access phase
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~addr_ok;

	// Address decode for the error answer; unaligned or
	// out-of-range addresses answer with an error
	always @*
	begin
		case (paddr)
			`ENABLE_OFS, `SET_PEND_OFS, `CLR_PEND_OFS, `ACTIVE_OFS,
			`TYPE_OFS, `GROUPING_OFS, `PRIO0_OFS, `PRIO1_OFS,
			`PRIO2_OFS, `SW_TRIG_OFS, `STATUS_OFS:
				addr_ok = 1'b1;
			default:
				addr_ok = 1'b0;
		endcase
	end

	// Read mux, sampled at the setup cycle; pending reads the
	// same through the set and the clear offsets
	always @*
	begin
		rdata_d = 32'h00000000;
		case (paddr)
			`ENABLE_OFS:
				rdata_d[NUM_IRQ-1:0] = enable_q;
			`SET_PEND_OFS, `CLR_PEND_OFS:
				rdata_d[NUM_IRQ-1:0] = pend_q;
			`ACTIVE_OFS:
				rdata_d[NUM_IRQ-1:0] = active_q;
			`TYPE_OFS:
				rdata_d[NUM_IRQ-1:0] = pulse_q;
			`GROUPING_OFS:
				rdata_d[`SUB_W-1:0] = grouping_q;
			`STATUS_OFS:
			begin
				rdata_d[`ID_W-1:0] = irq_id;
				rdata_d[`STAT_VALID_BIT] = irq_req;
				rdata_d[`STAT_PRIO_LSB +: `PRIO_W] = irq_prio;
				rdata_d[`STAT_NMI_BIT] = nmi_req;
			end
			default:
			begin
				// Priority words; unused fields read zero
				for (i = 0; i < NUM_IRQ; i = i + 1)
					if (prio_hit(paddr, i))
						rdata_d[field_lsb(i) +: `PRIO_W] = prio_q[i];
			end
		endcase
	end

	// Configuration writes take effect at the access-phase edge;
	// an unmapped address matches none of these, except an unaligned one inside a priority word, which still writes that word
	always @*
	begin
		enable_d = enable_q;
		pulse_d = pulse_q;
		grouping_d = grouping_q;
		if (wr_en && paddr == `ENABLE_OFS)
			enable_d = pwdata[NUM_IRQ-1:0];
		// Type bit: one selects pulse detection, zero level
		if (wr_en && paddr == `TYPE_OFS)
			pulse_d = pwdata[NUM_IRQ-1:0];
		if (wr_en && paddr == `GROUPING_OFS)
			grouping_d = pwdata[`SUB_W-1:0];
		for (j = 0; j < NUM_IRQ; j = j + 1)
		begin
			prio_d[j] = prio_q[j];
			// live priority rewrite; the new value
			// is used from the next arbitration on
			if (wr_en && prio_hit(paddr, j))
				prio_d[j] = pwdata[field_lsb(j) +: `PRIO_W];
		end
	end

	// Per-source pending and active state. Later assignments win,
	// so the order below puts every pending set after every clear: a
	// pending event landing in the same cycle as a clear is never lost
	always @*
	begin
		pend_d = pend_q;
		active_d = active_q;
		edge_in = irq_in & ~line_q;
		for (k = 0; k < NUM_IRQ; k = k + 1)
		begin
			// clear-pending write; a level line still
			// high keeps its pending bit
			if (wr_en && paddr == `CLR_PEND_OFS && pwdata[k])
				if (pulse_q[k] || !irq_in[k])
					pend_d[k] = 1'b0;
			// handler entry; the core stacks its state
			if (entry && entry_id == k[`ID_W-1:0])
			begin
				pend_d[k] = 1'b0;
				active_d[k] = 1'b1;
			end
			// handler return; a pulse source keeps
			// whatever was latched while its handler ran
			if (exit_ret && exit_id == k[`ID_W-1:0])
			begin
				active_d[k] = 1'b0;
				if (!pulse_q[k])
					pend_d[k] = irq_in[k];
			end
			if (wr_en && paddr == `SET_PEND_OFS && pwdata[k])
				pend_d[k] = 1'b1;
			if (wr_en && paddr == `SW_TRIG_OFS &&
				pwdata[`ID_W-1:0] == k[`ID_W-1:0])
				pend_d[k] = 1'b1;
			// pulse rising edge latched, also while active
			if (pulse_q[k] && edge_in[k])
				pend_d[k] = 1'b1;
			if (!pulse_q[k] && irq_in[k] && !active_d[k])
				pend_d[k] = 1'b1;
		end
	end

	// Arbitration over enabled pending sources. A linear scan gives
	// a long compare chain; at this clock rate it was judged
	// cheaper than a tree of comparators
	always @*
	begin
		best_valid = 1'b0;
		best_id = {`ID_W{1'b0}};
		best_prio = {`PRIO_W{1'b1}};
		run_group = `NO_GROUP;
		g = 4'h0;
		for (m = 0; m < NUM_IRQ; m = m + 1)
		begin
			// strict less keeps lowest number on ties
			if (enable_q[m] && pend_q[m] &&
				(!best_valid || prio_q[m] < best_prio))
			begin
				best_valid = 1'b1;
				best_id = m[`ID_W-1:0];
				best_prio = prio_q[m];
			end
			// running level is the most urgent active group
			// an empty active set leaves the idle marker
			g = group_of(prio_q[m], grouping_q);
			if (active_q[m] && g < run_group)
				run_group = g;
		end
	end

	// State registers; reset leaves every source disabled, level
	// type, priority zero, neither pending nor active
	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			enable_q <= {NUM_IRQ{1'b0}};
			pend_q <= {NUM_IRQ{1'b0}};
			active_q <= {NUM_IRQ{1'b0}};
			pulse_q <= {NUM_IRQ{1'b0}};
			line_q <= {NUM_IRQ{1'b0}}; // Idle level, no false edge
			grouping_q <= `GROUPING_RST;
			for (n = 0; n < NUM_IRQ; n = n + 1)
				prio_q[n] <= {`PRIO_W{1'b0}};
		end
		else
		begin
			enable_q <= enable_d;
			pend_q <= pend_d;
			active_q <= active_d;
			pulse_q <= pulse_d;
			line_q <= irq_in;
			grouping_q <= grouping_d;
			for (n = 0; n < NUM_IRQ; n = n + 1)
				prio_q[n] <= prio_d[n];
		end
	end

	// Core-facing outputs and staged read data
	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			irq_req <= 1'b0;
			irq_id <= {`ID_W{1'b0}};
			irq_prio <= {`PRIO_W{1'b0}};
			nmi_req <= 1'b0;
			prdata <= 32'h00000000;
		end
		else
		begin
			// only a more urgent group may preempt; the
			// subpriority only orders sources waiting together
			irq_req <= best_valid &&
				group_of(best_prio, grouping_q) < run_group;
			irq_id <= best_id;
			irq_prio <= best_prio;
			nmi_req <= nmi_in;
			// Staged once per transfer; stands until next setup
			if (setup)
				prdata <= rdata_d;
		end
	end

endmodule

/* File: test/irq_chk.sv */
// Port assertions for the interrupt pending logic
`timescale 1ns/100ps
`include "irq_ctrl_regs.vh"
module irq_chk
#(
	parameter NUM_IRQ = 22
)
(
	input wire core_clk,
	input wire rst_n,
	input wire [`ADDR_W-1:0] paddr,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire nmi_in,
	input wire irq_req,
	input wire [`ID_W-1:0] irq_id,
	input wire [`PRIO_W-1:0] irq_prio,
	input wire nmi_req
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// Access phase of one bus transfer
	sequence acc;
		psel && penable;
	endsequence
	sequence rd_of(logic [`ADDR_W-1:0] a);
		acc ##0 (!pwrite && paddr == a);
	endsequence
	a_always_ready: assert property (pready)
		else $error("ready low");
	a_err_unmapped: assert property (acc |-> pslverr ==
		(paddr[1:0] != 2'h0 || paddr > `STATUS_OFS))
		else $error("slave error wrong");
	a_nmi_delay: assert property ($past(rst_n) |->
		nmi_req == $past(nmi_in))
		else $error("nmi request late");
	a_id_in_range: assert property (irq_req |-> irq_id < NUM_IRQ)
		else $error("source number out of range");
	a_stat_id: assert property (rd_of(`STATUS_OFS) |->
		prdata[8] == $past(irq_req) && prdata[4:0] == $past(irq_id))
		else $error("status id mismatch");
	a_stat_prio: assert property (rd_of(`STATUS_OFS) |->
		prdata[11:9] == $past(irq_prio) && prdata[16] == $past(nmi_req))
		else $error("status priority mismatch");
	a_zero_reads: assert property (acc ##0 (!pwrite &&
		(paddr == `SW_TRIG_OFS || paddr > `STATUS_OFS)) |-> prdata == 32'h0)
		else $error("read not zero");
	a_disable_drop: assert property (acc ##0 (pwrite &&
		paddr == `ENABLE_OFS && pwdata[21:0] == 22'h0) |-> ##2 !irq_req)
		else $error("request while all disabled");
endmodule
bind vectored_irq_pending_logic irq_chk #(.NUM_IRQ(NUM_IRQ)) irq_chk_i (
	.core_clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
	.pready, .pslverr, .nmi_in, .irq_req, .irq_id, .irq_prio, .nmi_req);

/* File: test/periph_model.sv */
// Peripheral side: level and one-cycle pulse request lines
`timescale 1ns/100ps
module periph_model
(
	input wire core_clk,
	input wire [21:0] hold,
	input wire [21:0] pulse,
	output logic [21:0] irq_in = 22'h0
);
	always @(posedge core_clk)
		irq_in <= hold | pulse;
endmodule

/* File: test/testbench.sv */
// Self-checking bench for the interrupt pending logic
`timescale 1ns/100ps
`include "irq_ctrl_regs.vh"
module testbench;
	logic core_clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0;
	logic pwrite = 1'h0, nmi_in = 1'h0, entry = 1'h0, exit_ret = 1'h0;
	logic pready, pslverr, irq_req, nmi_req;
	logic [`ADDR_W-1:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd_q;
	logic err_q;
	logic [`ID_W-1:0] entry_id = 5'h0, exit_id = 5'h0, irq_id;
	logic [`PRIO_W-1:0] irq_prio;
	logic [21:0] hold = 22'h0, pulse = 22'h0, irq_in;
	int n_errors = 0;
	int checks = 0;
	vectored_irq_pending_logic vectored_irq_pending_logic_i (.core_clk,
		.rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
		.pslverr, .irq_in, .nmi_in, .irq_req, .irq_id, .irq_prio, .nmi_req,
		.entry, .entry_id, .exit_ret, .exit_id);
	periph_model periph_model_i (.core_clk, .hold, .pulse, .irq_in);
	initial
		forever #25 core_clk = ~core_clk;
	task automatic test_done;
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("Error %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	// One transfer; caller stands just after a rising edge
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int i;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'h1;
		i = 0;
		do
		begin
			@(posedge core_clk);
			i++;
		end
		while (pready !== 1'h1 && i < 40);
		if (i >= 40)
		begin
			n_errors++;
			test_done();
		end
		rd_q = prdata;
		err_q = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge core_clk);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'h0, a, 32'h0);
		chk(rd_q, exp);
	endtask
	task automatic st(input logic [31:0] pend, input logic [31:0] act);
		rd(`SET_PEND_OFS, pend);
		rd(`ACTIVE_OFS, act);
	endtask
	// Handler entry or return for one source
	task automatic core(input logic en, input logic ex, input int id);
		entry <= en;
		exit_ret <= ex;
		entry_id <= id[4:0];
		exit_id <= id[4:0];
		@(posedge core_clk);
		entry <= 1'h0;
		exit_ret <= 1'h0;
		@(posedge core_clk);
	endtask
	task automatic pl(input int n);
		pulse[n] <= 1'h1;
		@(posedge core_clk);
		pulse[n] <= 1'h0;
		repeat (3) @(posedge core_clk);
	endtask
	task automatic t_regs;
		rd(`ENABLE_OFS, 32'h0);
		rd(`TYPE_OFS, 32'h0);
		rd(`PRIO0_OFS, 32'h0);
		rd(12'h040, 32'h0);
		chk({31'h0, err_q}, 32'h1);
		$display("t_regs done");
	endtask
	task automatic t_pulse;
		apb(1'h1, `TYPE_OFS, 32'h8);
		apb(1'h1, `ENABLE_OFS, 32'h28);
		pl(3);
		rd(`STATUS_OFS, 32'h103);
		core(1'h1, 1'h0, 3);
		st(32'h0, 32'h8);
		pl(3);
		st(32'h8, 32'h8);
		apb(1'h1, `CLR_PEND_OFS, 32'h8);
		st(32'h0, 32'h8);
		pl(3);
		core(1'h0, 1'h1, 3);
		st(32'h8, 32'h0);
		apb(1'h1, `CLR_PEND_OFS, 32'h8);
		core(1'h1, 1'h0, 3);
		core(1'h0, 1'h1, 3);
		st(32'h0, 32'h0);
		$display("t_pulse done");
	endtask
	task automatic t_level;
		hold[5] <= 1'h1;
		repeat (3) @(posedge core_clk);
		st(32'h20, 32'h0);
		core(1'h1, 1'h0, 5);
		rd(`ACTIVE_OFS, 32'h20);
		core(1'h0, 1'h1, 5);
		st(32'h20, 32'h0);
		apb(1'h1, `CLR_PEND_OFS, 32'h20);
		rd(`SET_PEND_OFS, 32'h20);
		hold[5] <= 1'h0;
		repeat (2) @(posedge core_clk);
		apb(1'h1, `CLR_PEND_OFS, 32'h20);
		rd(`SET_PEND_OFS, 32'h0);
		$display("t_level done");
	endtask
	task automatic t_prio;
		apb(1'h1, `PRIO0_OFS, 32'h00205000);
		apb(1'h1, `SW_TRIG_OFS, 32'h3);
		apb(1'h1, `SW_TRIG_OFS, 32'h5);
		rd(`STATUS_OFS, 32'h505);
		apb(1'h1, `PRIO0_OFS, 32'h00605000);
		rd(`STATUS_OFS, 32'hB03);
		nmi_in <= 1'h1;
		apb(1'h1, `PRIO0_OFS, 32'h00505000);
		rd(`STATUS_OFS, 32'h10B03);
		apb(1'h1, `ENABLE_OFS, 32'h0);
		rd(`SET_PEND_OFS, 32'h28);
		$display("t_prio done");
	endtask
	// Source 3 runs at 2, source 5 waits at 1: same group when two
	// subpriority bits are set, so no preemption; source 5 preempts when cleared
	task automatic t_group;
		nmi_in <= 1'h0;
		apb(1'h1, `PRIO0_OFS, 32'h00102000);
		apb(1'h1, `GROUPING_OFS, 32'h2);
		apb(1'h1, `ENABLE_OFS, 32'h28);
		core(1'h1, 1'h0, 3);
		rd(`STATUS_OFS, 32'h205);
		apb(1'h1, `GROUPING_OFS, 32'h0);
		rd(`STATUS_OFS, 32'h305);
		rd(`GROUPING_OFS, 32'h0);
		$display("t_group done");
	endtask
	initial
	begin
		repeat (10) @(posedge core_clk);
		rst_n <= 1'h1;
		@(posedge core_clk);
		t_regs();
		t_pulse();
		t_level();
		t_prio();
		t_group();
		test_done();
	end
endmodule
